// ==== logic/ccg_pkg.sv ====
// Shared constants for the card clock and bit time unit generator
package ccg_pkg;
  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADDR_DIV_CFG   = 4'h0;
  localparam logic [3:0] ADDR_ETU_LOW   = 4'h1;
  localparam logic [3:0] ADDR_ETU_HIGH  = 4'h2;
  localparam logic [3:0] ADDR_PWR_CTRL  = 4'h3;
  localparam logic [3:0] ADDR_STATUS    = 4'h4;
  localparam int         ADDR_W         = 4;
  localparam int         DATA_W         = 8;

  // ---------------------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------------------
  localparam int         DIV_SEL_LSB    = 0;
  localparam int         DIV_SEL_W      = 3;
  localparam int         START_BIT      = 0;
  localparam int         ST_CLK_ON_BIT  = 0;
  localparam int         ST_ACTIVE_BIT  = 1;
  localparam logic [2:0] DIV_SEL_RST    = 3'h5;
  localparam logic [7:0] ETU_LOW_RST    = 8'hb8;
  localparam logic [7:0] ETU_HIGH_RST   = 8'h08;
  localparam logic [15:0] ETU_LEN_MIN   = 16'h0010;

  // ---------------------------------------------------------------------------
  // Divider ratio table, indexed by divider code
  // ---------------------------------------------------------------------------
  localparam int         RATIO_W        = 5;
  localparam logic [4:0] RATIO_TABLE [8] = '{5'h01, 5'h02, 5'h03, 5'h04,
                                             5'h05, 5'h06, 5'h08, 5'h10};

  // Input clock of the interface, in kHz
  localparam int         SYS_CLK_KHZ    = 27120;
endpackage

// ==== logic/ccg_clk_div.sv ====
// Card clock divider driven from the interface input clock
`timescale 1ns/100ps
module ccg_clk_div (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [2:0] div_sel,
  output logic            card_clk
);
  typedef struct packed {
    logic [4:0] cnt;
    logic       clk;
  } ccg_div_s;

  ccg_div_s st_r;
  ccg_div_s st_nxt;
  logic [4:0] ratio;
  logic [4:0] half;

  // Ratio lookup by divider code, ascending
  assign ratio = ccg_pkg::RATIO_TABLE[div_sel]; // RULE16 RULE5
  assign half  = ratio >> 1;

  // Counter on the input clock; odd ratios above one give a high phase one cycle shorter
  always_comb begin
    st_nxt = st_r;
    if (!run) begin
      st_nxt.cnt = 5'h00;
      st_nxt.clk = 1'b0;
    end else if (ratio == 5'h01) begin
      st_nxt.cnt = 5'h00;
      st_nxt.clk = 1'b1;
    end else begin
      if (st_r.cnt >= ratio - 5'h01) begin
        st_nxt.cnt = 5'h00;
      end else begin
        st_nxt.cnt = st_r.cnt + 5'h01;
      end
      st_nxt.clk = (st_nxt.cnt < half); // RULE12
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Divide by one passes the input clock straight through while running
  assign card_clk = (run && ratio == 5'h01) ? mclk : st_r.clk;
endmodule

// ==== logic/ccg_etu_cnt.sv ====
// Bit time unit counter on the interface input clock
`timescale 1ns/100ps
module ccg_etu_cnt (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic [15:0] etu_length_count,
  output logic             etu_tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } ccg_etu_s;

  ccg_etu_s st_r;
  ccg_etu_s st_nxt;

  // Counts input clock cycles; zero wraps to 65536 naturally
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (!run) begin
      st_nxt.cnt = 16'h0000;
    end else if (st_r.cnt == etu_length_count - 16'h0001) begin // RULE11 RULE17
      st_nxt.cnt  = 16'h0000;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign etu_tick = st_r.tick; // RULE9
endmodule

// ==== logic/ccg_top.sv ====
// Card clock and bit time unit generator, register slave and top level
//
// Summary of operation
// RULE1: Host enables interface clock and peripheral clock before use.
// RULE2: After reset the input clock runs at its default 27.12 MHz.
// RULE3: Card clock is driven automatically once activation is requested.
// RULE4: Three-bit divider field sits in bits zero to two.
// RULE5: Divider supports ratios 1, 2, 3, 4, 5, 6, 8 and 16.
// RULE6: Host keeps card clock below 5 MHz for activation; divide by six.
// RULE7: Host writes divider before requesting activation.
// RULE8: During activation one unit lasts 372 card clock cycles.
// RULE9: One unit is exactly one bit period on the data line.
// RULE10: Units are timed by counting clocks of the data transfer clock.
// RULE11: Unit counter counts input clock cycles, not card clock.
// RULE12: Divider and unit counter share the one input clock.
// RULE13: Unit length from 16 to 65536 cycles, across low and high bytes.
// RULE14: Unit in card clocks equals count over ratio, possibly fractional.
// RULE15: Activation and card clock start when host sets the start bit.
// RULE16: Codes 000 to 111 map in order to the eight ratios.
// RULE17: An all-zero unit length selects 65536 cycles.
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
module ccg_top (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  output logic            card_clk,
  output logic            etu_tick,
  output logic            card_active
);
  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] card_clock_div_sel;
    logic [7:0] etu_length_low;
    logic [7:0] etu_length_high;
    logic       start;
    logic [7:0] rdata;
  } ccg_regs_s;

  ccg_regs_s   st_r;
  ccg_regs_s   st_nxt;
  logic [15:0] wr_len;
  logic [15:0] etu_length_count;

  // Candidate length after a byte write, used for the minimum check
  always_comb begin
    wr_len = {st_r.etu_length_high, st_r.etu_length_low};
    if (addr == ccg_pkg::ADDR_ETU_LOW) begin
      wr_len = {st_r.etu_length_high, wdata};
    end else if (addr == ccg_pkg::ADDR_ETU_HIGH) begin
      wr_len = {wdata, st_r.etu_length_low};
    end
  end

  // ---------------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------------
  // A byte write that would make a nonzero length below 16 is clamped, since
  // shorter units leave the bit logic no time to work
  always_comb begin
    st_nxt       = st_r;
    st_nxt.rdata = 8'h00;
    if (wr) begin
      unique case (addr)
        ccg_pkg::ADDR_DIV_CFG: begin
          st_nxt.card_clock_div_sel = wdata[ccg_pkg::DIV_SEL_LSB +: ccg_pkg::DIV_SEL_W]; // RULE4
        end
        ccg_pkg::ADDR_ETU_LOW, ccg_pkg::ADDR_ETU_HIGH: begin
          if (wr_len != 16'h0000 && wr_len < ccg_pkg::ETU_LEN_MIN) begin // RULE13
            st_nxt.etu_length_high = 8'h00;
            st_nxt.etu_length_low  = ccg_pkg::ETU_LEN_MIN[7:0];
          end else begin
            st_nxt.etu_length_high = wr_len[15:8];
            st_nxt.etu_length_low  = wr_len[7:0];
          end
        end
        ccg_pkg::ADDR_PWR_CTRL: begin
          st_nxt.start = wdata[ccg_pkg::START_BIT]; // RULE15
        end
        default: begin
        end
      endcase
    end
    if (rd) begin
      unique case (addr)
        ccg_pkg::ADDR_DIV_CFG:  st_nxt.rdata = {5'h00, st_r.card_clock_div_sel};
        ccg_pkg::ADDR_ETU_LOW:  st_nxt.rdata = st_r.etu_length_low;
        ccg_pkg::ADDR_ETU_HIGH: st_nxt.rdata = st_r.etu_length_high;
        ccg_pkg::ADDR_PWR_CTRL: st_nxt.rdata = {7'h00, st_r.start};
        ccg_pkg::ADDR_STATUS:   st_nxt.rdata = {6'h00, st_r.start, st_r.start};
        default:                st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // Reset defaults: divide by six, 2232-cycle unit (372 card clocks) for activation
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r.card_clock_div_sel <= ccg_pkg::DIV_SEL_RST; // RULE2
      st_r.etu_length_low     <= ccg_pkg::ETU_LOW_RST; // RULE8
      st_r.etu_length_high    <= ccg_pkg::ETU_HIGH_RST;
      st_r.start              <= 1'b0;
      st_r.rdata              <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Clock and unit generation, both on mclk
  // ---------------------------------------------------------------------------
  assign etu_length_count = {st_r.etu_length_high, st_r.etu_length_low};
  assign rdata            = st_r.rdata;
  assign card_active      = st_r.start;

  // Card clock runs as soon as start is set, no further host action
  ccg_clk_div u_div (
    .mclk     (mclk),
    .rst      (rst),
    .run      (st_r.start), // RULE3 RULE12
    .div_sel  (st_r.card_clock_div_sel),
    .card_clk (card_clk)
  );

  // Unit counter shares mclk, so count over ratio gives the fractional unit
  ccg_etu_cnt u_etu (
    .mclk             (mclk),
    .rst              (rst),
    .run              (st_r.start), // RULE10 RULE14
    .etu_length_count (etu_length_count),
    .etu_tick         (etu_tick)
  );

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence s_start_write;
    wr && addr == ccg_pkg::ADDR_PWR_CTRL && wdata[ccg_pkg::START_BIT];
  endsequence

  AST_START_ACTIVE: assert property (@(posedge mclk) disable iff (rst) // RULE15
    s_start_write |=> card_active)
    else $error("start write did not activate");

  AST_DIV_FIELD: assert property (@(posedge mclk) disable iff (rst) // RULE4
    wr && addr == ccg_pkg::ADDR_DIV_CFG |=> st_r.card_clock_div_sel == $past(wdata[2:0]))
    else $error("divider field not stored");

  AST_LEN_MIN: assert property (@(posedge mclk) disable iff (rst) // RULE13
    etu_length_count == 16'h0000 || etu_length_count >= ccg_pkg::ETU_LEN_MIN)
    else $error("unit length below minimum");

  AST_IDLE_CLK: assert property (@(posedge mclk) disable iff (rst) // RULE3
    !card_active |=> !card_clk)
    else $error("card clock runs while inactive");

  AST_NO_TICK_IDLE: assert property (@(posedge mclk) disable iff (rst) // RULE10
    !card_active ##1 !card_active |-> !etu_tick)
    else $error("unit tick while inactive");

  AST_TICK_SPACING: assert property (@(posedge mclk) disable iff (rst) // RULE9
    etu_tick && card_active |=> !etu_tick)
    else $error("unit ticks too close");

  AST_READ_LOW: assert property (@(posedge mclk) disable iff (rst) // RULE13
    rd && addr == ccg_pkg::ADDR_ETU_LOW && !wr |=> rdata == $past(st_r.etu_length_low))
    else $error("low byte readback wrong");

  AST_RESET_DIV: assert property (@(posedge mclk) // RULE2
    $past(rst) |-> st_r.card_clock_div_sel == ccg_pkg::DIV_SEL_RST)
    else $error("divider reset value wrong");

  // ---------------------------------------------------------------------------
  // Checks on stop, reset and the register port
  // ---------------------------------------------------------------------------
  // Decodes of the register port, kept apart from the register file
  logic len_sel;
  logic len_too_short;
  assign len_sel       = addr == ccg_pkg::ADDR_ETU_LOW || addr == ccg_pkg::ADDR_ETU_HIGH;
  assign len_too_short = wr_len != 16'h0000 && wr_len < ccg_pkg::ETU_LEN_MIN;

  // Host clears the start bit
  sequence s_stop_write;
    wr && addr == ccg_pkg::ADDR_PWR_CTRL && !wdata[ccg_pkg::START_BIT];
  endsequence

  // A byte write that would leave the unit too short
  sequence s_len_clamp;
    wr && len_sel && len_too_short;
  endsequence

  // No unit tick for two cycles in a row
  sequence s_two_quiet;
    !etu_tick ##1 !etu_tick;
  endsequence

  // Clearing start drops the active flag on the next edge
  AST_STOP_IDLE: assert property (@(posedge mclk) disable iff (rst) // RULE15
    s_stop_write
    |=> !card_active)
    else $error("stop write did not deactivate");

  // Divider sees run low one edge later, so the clock settles low after two
  AST_STOP_CLK: assert property (@(posedge mclk) disable iff (rst) // RULE3
    s_stop_write
    |-> ##2 !card_clk)
    else $error("card clock still running after stop");

  // A tick already in flight may show once, then the counter is quiet
  AST_STOP_TICK: assert property (@(posedge mclk) disable iff (rst) // RULE10
    s_stop_write
    |-> ##2 s_two_quiet)
    else $error("unit tick after stop");

  // Counter restarts from zero, so no tick right after activation
  AST_TICK_FIRST: assert property (@(posedge mclk) disable iff (rst) // RULE13
    $rose(card_active)
    |-> s_two_quiet)
    else $error("unit tick too soon after start");

  // Slowest ratio is sixteen, so the first high phase comes within twenty
  AST_CLK_STARTS: assert property (@(posedge mclk) disable iff (rst) // RULE3
    $rose(card_active) && st_r.card_clock_div_sel != '0
    |-> ##[1:20] card_clk)
    else $error("card clock did not start");

  // The divided clock leaves its idle level from low
  AST_CLK_FIRST_LOW: assert property (@(posedge mclk) disable iff (rst) // RULE3
    $rose(card_active) && st_r.card_clock_div_sel != '0
    |-> !card_clk)
    else $error("card clock high at start");

  // A legal byte write lands as written
  AST_LEN_WRITE: assert property (@(posedge mclk) disable iff (rst) // RULE13
    wr && len_sel && !len_too_short
    |=> etu_length_count == $past(wr_len))
    else $error("unit length not stored");

  // A too short length is pulled up to the minimum
  AST_LEN_CLAMP: assert property (@(posedge mclk) disable iff (rst) // RULE13
    s_len_clamp
    |=> etu_length_count == ccg_pkg::ETU_LEN_MIN)
    else $error("unit length not clamped");

  // Zero is kept, since it stands for the longest unit
  AST_LEN_ZERO_OK: assert property (@(posedge mclk) disable iff (rst) // RULE17
    wr && len_sel && wr_len == 16'h0000
    |=> etu_length_count == 16'h0000)
    else $error("zero unit length not kept");

  // Writing the high byte leaves the low byte alone unless the length is clamped
  AST_HIGH_KEEPS_LOW: assert property (@(posedge mclk) disable iff (rst) // RULE13
    wr && addr == ccg_pkg::ADDR_ETU_HIGH && !len_too_short
    |=> $stable(st_r.etu_length_low))
    else $error("high byte write changed low byte");

  // Writing the low byte leaves the high byte alone
  AST_LOW_KEEPS_HIGH: assert property (@(posedge mclk) disable iff (rst) // RULE13
    wr && addr == ccg_pkg::ADDR_ETU_LOW && !len_too_short
    |=> $stable(st_r.etu_length_high))
    else $error("low byte write changed high byte");

  // Length moves only on its own writes
  AST_LEN_HOLD: assert property (@(posedge mclk) disable iff (rst) // RULE13
    !(wr && len_sel)
    |=> $stable(etu_length_count))
    else $error("unit length changed without a write");

  // Divider code moves only on its own write
  AST_DIV_HOLD: assert property (@(posedge mclk) disable iff (rst) // RULE4
    !(wr && addr == ccg_pkg::ADDR_DIV_CFG)
    |=> $stable(st_r.card_clock_div_sel))
    else $error("divider changed without a write");

  // Active flag moves only on a power control write
  AST_START_HOLD: assert property (@(posedge mclk) disable iff (rst) // RULE15
    !(wr && addr == ccg_pkg::ADDR_PWR_CTRL)
    |=> $stable(card_active))
    else $error("active flag changed without a write");

  // Read data is zero outside the answer cycle
  AST_RDATA_IDLE: assert property (@(posedge mclk) disable iff (rst) // RULE13
    !rd
    |=> rdata == 8'h00)
    else $error("read data not cleared");

  // Divider code reads back in the low bits
  AST_READ_DIV: assert property (@(posedge mclk) disable iff (rst) // RULE4
    rd && addr == ccg_pkg::ADDR_DIV_CFG
    |=> rdata == {5'h00, $past(st_r.card_clock_div_sel)})
    else $error("divider readback wrong");

  // High length byte reads back
  AST_READ_HIGH: assert property (@(posedge mclk) disable iff (rst) // RULE13
    rd && addr == ccg_pkg::ADDR_ETU_HIGH
    |=> rdata == $past(st_r.etu_length_high))
    else $error("high byte readback wrong");

  // Status shows clock on and active together
  AST_READ_STATUS: assert property (@(posedge mclk) disable iff (rst) // RULE3
    rd && addr == ccg_pkg::ADDR_STATUS
    |=> rdata == {6'h00, $past(card_active), $past(card_active)})
    else $error("status readback wrong");

  // Start bit reads back
  AST_READ_START: assert property (@(posedge mclk) disable iff (rst) // RULE15
    rd && addr == ccg_pkg::ADDR_PWR_CTRL
    |=> rdata == {7'h00, $past(card_active)})
    else $error("start readback wrong");

  // Holes in the map read as zero
  AST_READ_HOLE: assert property (@(posedge mclk) disable iff (rst) // RULE4
    rd && addr > ccg_pkg::ADDR_STATUS
    |=> rdata == 8'h00)
    else $error("unmapped read not zero");

  // Outputs come out of reset quiet
  AST_RESET_OUT: assert property (@(posedge mclk) // RULE2
    $past(rst)
    |-> !card_active && !etu_tick && rdata == 8'h00)
    else $error("outputs not quiet after reset");

  // Reset length gives 372 card clocks at the reset divider
  AST_RESET_LEN: assert property (@(posedge mclk) // RULE8
    $past(rst)
    |-> etu_length_count == {ccg_pkg::ETU_HIGH_RST, ccg_pkg::ETU_LOW_RST})
    else $error("unit length reset value wrong");

  // A tick is only made while the counter was running
  AST_TICK_RUN: assert property (@(posedge mclk) disable iff (rst) // RULE11
    etu_tick
    |-> $past(card_active))
    else $error("unit tick without activation");

  // A divided clock high phase only follows an active cycle
  AST_CLK_RUN: assert property (@(posedge mclk) disable iff (rst) // RULE3
    card_clk
    |-> $past(card_active))
    else $error("card clock high without activation");

  // Minimum length of sixteen keeps ticks well apart
  AST_TICK_GAP: assert property (@(posedge mclk) disable iff (rst) // RULE13
    etu_tick
    |=> !etu_tick [*8])
    else $error("unit ticks closer than the minimum");
endmodule

// ==== verification/ccg_card_model.sv ====
// Card side model that counts card clock edges per bit time unit
`timescale 1ns/100ps
module ccg_card_model (
  input wire logic card_clk,
  input wire logic etu_tick
);
  int edges = 0;
  int per_unit = 0;
  // The card only sees its own clock
  always @(posedge card_clk) begin
    edges++;
  end
  // Snapshot at each unit boundary; the bench tolerates a one-edge race
  always @(posedge etu_tick) begin
    per_unit = edges;
    edges = 0;
  end
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the card clock and bit time unit generator
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %0t %h %h", $time, (a), (e)); end end
module tb_top;
  logic       mclk;
  logic       rst;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       card_clk;
  logic       etu_tick;
  logic       card_active;
  int         mismatches = 0;
  int         num_checks = 0;
  int         cycles = 0;
  int         n;
  logic [7:0] v;
  ccg_top u_dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .card_clk(card_clk), .etu_tick(etu_tick), .card_active(card_active));
  ccg_card_model u_card (.card_clk(card_clk), .etu_tick(etu_tick));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Hang guard: longest unit is 65536 cycles, the rest a few thousand
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 95000) begin
      mismatches++;
      summarize();
    end
  end
  // Expected division ratio, kept apart from the design's table
  function automatic int ratio(input logic [2:0] c);
    return (c == 3'h7) ? 16 : (c == 3'h6) ? 8 : int'(c) + 1;
  endfunction
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  // Bounded wait for the next unit tick, counting clocks
  task automatic wait_tick(output int c);
    c = 0;
    do begin
      @(posedge mclk);
      #1;
      c++;
    end while (etu_tick !== 1'b1 && c < 70000);
  endtask
  // Card clock must stay quiet while the card is not active
  task automatic idle_chk();
    logic seen;
    seen = 1'b0;
    repeat (3) @(posedge mclk);
    repeat (40) begin
      #10;
      seen = seen | card_clk;
    end
    `CHK(seen, 1'b0)
    `CHK(card_active, 1'b0)
  endtask
  task automatic run_case(input logic [2:0] code, input logic [15:0] len);
    int r;
    int e;
    int pu;
    r = ratio(code);
    e = (len == 16'h0000) ? 65536 : (len < 16'h0010) ? 16 : int'(len);
    wr_reg(ccg_pkg::ADDR_DIV_CFG, {5'h00, code});
    wr_reg(ccg_pkg::ADDR_ETU_HIGH, len[15:8]);
    wr_reg(ccg_pkg::ADDR_ETU_LOW, len[7:0]);
    rd_chk(ccg_pkg::ADDR_DIV_CFG, {5'h00, code});
    wr_reg(ccg_pkg::ADDR_PWR_CTRL, 8'h01);
    wait_tick(n);
    if (e == 65536) begin
      `CHK(n > 65530 && n < 65542, 1'b1)
    end else begin
      wait_tick(n);
      `CHK(n, e)
      pu = u_card.per_unit;
      `CHK(pu * r + r >= e && pu * r <= e + r, 1'b1)
    end
    rd_chk(ccg_pkg::ADDR_STATUS, 8'h03);
    wr_reg(ccg_pkg::ADDR_PWR_CTRL, 8'h00);
    idle_chk();
  endtask
  // Main sequence: reset values, corners, then every code with random lengths
  initial begin
    rst = 1'b1;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    v = 8'($urandom(36));
    rd_chk(ccg_pkg::ADDR_DIV_CFG, 8'h05);
    rd_chk(ccg_pkg::ADDR_ETU_LOW, 8'hb8);
    rd_chk(ccg_pkg::ADDR_ETU_HIGH, 8'h08);
    wr_reg(4'hf, 8'hff);
    rd_chk(4'hf, 8'h00);
    idle_chk();
    // Activation on reset defaults, then a reset while the card is active
    wr_reg(ccg_pkg::ADDR_PWR_CTRL, 8'h01);
    wait_tick(n);
    wait_tick(n);
    `CHK(n, 372 * 6)
    `CHK(u_card.per_unit > 370 && u_card.per_unit < 374, 1'b1)
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    `CHK(card_active, 1'b0)
    rd_chk(ccg_pkg::ADDR_STATUS, 8'h00);
    rd_chk(ccg_pkg::ADDR_DIV_CFG, 8'h05);
    idle_chk();
    run_case(3'h5, 16'h0010);
    run_case(3'h0, 16'h0005);
    run_case(3'h7, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      run_case(3'(i), 16'h0010 + 16'($urandom % 385));
    end
    summarize();
  end
  task automatic summarize();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
endmodule
